// >>> logic/sdt_defs.svh
// Register map, field positions, reset values and timing counts of the down timer
`ifndef SDT_DEFS_SVH
`define SDT_DEFS_SVH

// Register indices; byte address is four times the index
`define SDT_IDX_RELOAD_HIGH 8'hF0
`define SDT_IDX_RELOAD_LOW 8'hF1
`define SDT_IDX_PRESCALE 8'hF2
`define SDT_IDX_CONTROL 8'hF3

// Control register bit positions
`define SDT_BIT_RUN 7
`define SDT_BIT_SINGLE 6
`define SDT_BIT_IN_FIRST 5
`define SDT_BIT_IN_SECOND 4
`define SDT_BIT_IN_ENABLE 3
`define SDT_BIT_IRQ_SEL 2
`define SDT_BIT_OUT_FIRST 1
`define SDT_BIT_OUT_SECOND 0

// Reset values
`define SDT_RST_RELOAD_HIGH 8'hFF
`define SDT_RST_RELOAD_LOW 8'hFF
`define SDT_RST_PRESCALE 8'hFF
`define SDT_RST_CONTROL 8'h14

// Core clock divided by this feeds the prescaler
`define SDT_CORE_DIV 4
// Least spacing of count pin falling edges, in core clock periods
`define SDT_EVENT_SPACING 8

`endif

// >>> logic/sdt_pkg.sv
// Types shared by the down timer modules
package sdt_pkg;

    typedef enum logic [1:0] {
        SDT_IN_EVENT = 2'b00,
        SDT_IN_GATED = 2'b01,
        SDT_IN_TRIG = 2'b10,
        SDT_IN_RETRIG = 2'b11
    } sdt_in_mode_t;

    typedef struct packed {
        logic run_bit;
        logic single;
        sdt_in_mode_t in_mode;
        logic input_section_enable;
        logic irq_source_select;
        logic output_mode_first;
        logic output_mode_second;
    } sdt_ctrl_t;

    typedef struct packed {
        logic [7:0] count;
    } sdt_psc_state_t;

    typedef struct packed {
        sdt_ctrl_t ctrl;
        logic [15:0] count;
        logic [15:0] reload;
        logic [7:0] prescale;
        logic pending;
        logic armed;
        logic sync_first;
        logic sync_second;
        logic pin_prev;
        logic [1:0] div_cnt;
        logic out_pin;
        logic irq;
        logic waitreq;
        logic [31:0] rdata;
    } sdt_state_t;

endpackage

// >>> logic/sdt_prescaler.sv
// Programmable 8-bit prescaler: passes one tick out of value+1 ticks in
`timescale 1ns/1ns
`include "sdt_defs.svh"

module sdt_prescaler
    import sdt_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic tick_in,
    input wire logic load,
    input wire logic [WIDTH-1:0] value,
    output logic tick_out
);

    generate
        if (WIDTH != 8) begin : g_bad_width
            $error("sdt_prescaler supports only an 8-bit divider");
        end
    endgenerate

    sdt_psc_state_t st;
    sdt_psc_state_t next_st;

    // Value 0 passes every tick, value FF passes one in 256
    assign tick_out = tick_in && !load && (st.count == 8'h00);

    always_comb begin
        next_st = st;
        if (load) begin
            next_st.count = value;
        end else if (tick_in) begin
            if (st.count == 8'h00) begin
                next_st.count = value;
            end else begin
                next_st.count = st.count - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st.count <= `SDT_RST_PRESCALE;
        end else begin
            st <= next_st;
        end
    end

endmodule

// >>> logic/sdt_top.sv
// Standard 16-bit down timer with prescaler, input modes, output modes, Avalon-MM slave
//
// Summary of operation
// - 16-bit down counter, 8-bit prescaler, single/continuous.
// - Prescaler fed by core/4, oscillator clock or pin.
// - Underflow past zero is end-of-count, requests interrupt.
// - Run bit set starts counting, clear halts.
// - Restart resumes held value unless constant rewritten.
// - Running: constant at end-of-count, prescaler immediately.
// - Reset leaves both counter bytes, prescaler all-ones.
// - Single: end-of-count stops, reloads, clears run.
// - Continuous: end-of-count reloads and keeps counting.
// - Mode bit and run bit writable together anytime.
// - Input disabled: core/4 clock, pin ignored.
// - Event mode counts each pin falling edge.
// - Gated mode counts core/4 while pin high.
// - Trigger mode starts on run plus falling edge.
// - Retrigger edge restarts from constant while running.
// - Without pin, event mode counts oscillator clock.
// - Output mode zero drives the output pin high.
// - Square-wave mode inverts output at end-of-count.
// - PWM mode copies second output bit at end-of-count.
// - Select bit swaps timer interrupt for external pin.
// - Four registers: high, low, prescaler, control, base first.
// - Prescaler 0 no division, FF by 256, reads programmed.
// - Counter bytes write constant, read live count.
`timescale 1ns/1ns
`include "sdt_defs.svh"

module sdt_top
    import sdt_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter bit HAS_COUNT_PIN = 1'b1
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic count_input_pin,
    input wire logic oscillator_derived_clock,
    input wire logic ext_irq_pin,
    output logic timer_output_pin,
    output logic irq_channel
);

    generate
        if (ADDR_W < 10) begin : g_bad_addr
            $error("sdt_top needs at least 10 address bits for its register map");
        end
        if (`SDT_CORE_DIV != 4) begin : g_bad_div
            $error("sdt_top derives its core divider from a two-bit phase counter");
        end
        if (`SDT_BIT_RUN != 7 || `SDT_BIT_SINGLE != 6 || `SDT_BIT_IN_ENABLE != 3
            || `SDT_BIT_OUT_SECOND != 0) begin : g_bad_fields
            $error("sdt_top control fields must match the packed control struct");
        end
        if (`SDT_EVENT_SPACING < 3) begin : g_bad_spacing
            $error("pin edges closer than the three-flop detector path are lost");
        end
    endgenerate

    sdt_state_t st;
    sdt_state_t next_st;

    // Byte address of a register index
    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        hits = (addr == ADDR_W'({idx, 2'b00}));
    endfunction

    function automatic logic [7:0] ctrl_byte(input sdt_ctrl_t c);
        ctrl_byte = {c.run_bit,
                     c.single,
                     c.in_mode,
                     c.input_section_enable,
                     c.irq_source_select,
                     c.output_mode_first,
                     c.output_mode_second};
    endfunction

    // Inverse of ctrl_byte; takes field positions from the defines, where ctrl_byte uses the struct order
    function automatic sdt_ctrl_t ctrl_of_byte(input logic [7:0] b);
        sdt_ctrl_t c;
        c.run_bit = b[`SDT_BIT_RUN];
        c.single = b[`SDT_BIT_SINGLE];
        c.in_mode = sdt_in_mode_t'({b[`SDT_BIT_IN_FIRST], b[`SDT_BIT_IN_SECOND]});
        c.input_section_enable = b[`SDT_BIT_IN_ENABLE];
        c.irq_source_select = b[`SDT_BIT_IRQ_SEL];
        c.output_mode_first = b[`SDT_BIT_OUT_FIRST];
        c.output_mode_second = b[`SDT_BIT_OUT_SECOND];
        ctrl_of_byte = c;
    endfunction

    // Write strobe of one register: committed write with lane 0 on a matching address
    function automatic logic wr_hit(input logic commit,
                                    input logic lane,
                                    input logic [ADDR_W-1:0] addr,
                                    input logic [7:0] idx);
        wr_hit = commit && lane && hits(addr, idx);
    endfunction

    // Counter bytes read the live count, the prescaler its programmed value
    function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] addr,
                                             input sdt_state_t s);
        read_byte = 8'h00;
        if (hits(addr, `SDT_IDX_RELOAD_HIGH)) begin
            read_byte = s.count[15:8];
        end else if (hits(addr, `SDT_IDX_RELOAD_LOW)) begin
            read_byte = s.count[7:0];
        end else if (hits(addr, `SDT_IDX_PRESCALE)) begin
            read_byte = s.prescale;
        end else if (hits(addr, `SDT_IDX_CONTROL)) begin
            read_byte = ctrl_byte(s.ctrl);
        end
    endfunction

    // Output pin next level; mode 00 forces high so the pin is free for other use
    function automatic logic out_next(input sdt_ctrl_t c, input logic cur, input logic at_eoc);
        out_next = cur;
        if (!c.output_mode_first && !c.output_mode_second) begin
            out_next = 1'b1;
        end else if (at_eoc) begin
            if (c.output_mode_first) begin
                out_next = c.output_mode_second;
            end else begin
                out_next = !cur;
            end
        end
    endfunction

    // Bus phase: request held by master, answer cycle shows waitrequest low
    logic bus_req;
    logic bus_commit;
    logic wr_commit;
    logic lane0;
    logic wr_high;
    logic wr_low;
    logic wr_psc;
    logic wr_ctrl;
    logic [7:0] wbyte;

    assign bus_req = avs_read || avs_write;
    assign bus_commit = bus_req && !st.waitreq;
    assign wr_commit = avs_write && !st.waitreq;
    // Only lane 0 carries a register; other lanes are ignored
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign wr_high = wr_hit(wr_commit, lane0, avs_address, `SDT_IDX_RELOAD_HIGH);
    assign wr_low = wr_hit(wr_commit, lane0, avs_address, `SDT_IDX_RELOAD_LOW);
    assign wr_psc = wr_hit(wr_commit, lane0, avs_address, `SDT_IDX_PRESCALE);
    assign wr_ctrl = wr_hit(wr_commit, lane0, avs_address, `SDT_IDX_CONTROL);

    // Pin edge detection; first synchroniser stage is read only by the second
    logic pin_fall;
    logic pin_high;
    assign pin_fall = st.pin_prev && !st.sync_second;
    assign pin_high = st.sync_second;

    // Core clock divided by four as a one-cycle enable
    logic core_div_tick;
    assign core_div_tick = (st.div_cnt == 2'(`SDT_CORE_DIV - 1));

    logic running;
    logic retrig;
    logic src_tick;
    logic psc_load;
    logic psc_tick;
    logic eoc;
    logic start_edge;
    logic [7:0] next_prescale;

    // Registered run bit; a control write acts from the following cycle
    assign running = st.ctrl.run_bit;
    assign start_edge = wr_ctrl && wbyte[`SDT_BIT_RUN] && !running;

    // Retrigger only while running; a stopped timer ignores the edge
    assign retrig = running && st.ctrl.input_section_enable
                    && (st.ctrl.in_mode == SDT_IN_RETRIG) && pin_fall;

    // Clock source ahead of the prescaler
    always_comb begin
        src_tick = 1'b0;
        if (!st.ctrl.input_section_enable) begin
            src_tick = core_div_tick;
        end else begin
            case (st.ctrl.in_mode)
                SDT_IN_EVENT: begin
                    src_tick = pin_fall;
                end
                SDT_IN_GATED: begin
                    src_tick = core_div_tick && pin_high;
                end
                SDT_IN_TRIG: begin
                    src_tick = core_div_tick && st.armed;
                end
                SDT_IN_RETRIG: begin
                    src_tick = core_div_tick;
                end
                default: begin
                    src_tick = 1'b0;
                end
            endcase
        end
        src_tick = src_tick && running;
    end

    // New prescaler value acts at once; start and retrigger restart it
    assign next_prescale = wr_psc ? wbyte : st.prescale;
    assign psc_load = wr_psc || retrig || start_edge;

    sdt_prescaler #(
        .WIDTH(8)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .srst(srst),
        .tick_in(src_tick),
        .load(psc_load),
        .value(next_prescale),
        .tick_out(psc_tick)
    );

    // End of count: a tick arriving while the counter already holds zero
    assign eoc = psc_tick && !retrig && (st.count == 16'h0000);

    always_comb begin
        next_st = st;
        next_st.waitreq = 1'b1;

        // Input pin synchroniser and edge history
        // Stages reset high, the idle level, so no false edge follows reset
        next_st.sync_first = HAS_COUNT_PIN ? count_input_pin : oscillator_derived_clock;
        next_st.sync_second = st.sync_first;
        next_st.pin_prev = st.sync_second;

        // Free running divide-by-four phase
        if (core_div_tick) begin
            next_st.div_cnt = 2'b00;
        end else begin
            next_st.div_cnt = st.div_cnt + 2'b01;
        end

        // Register writes
        // Pending marks a constant the counter has not yet taken
        if (wr_high) begin
            next_st.reload[15:8] = wbyte;
            next_st.pending = 1'b1;
        end
        if (wr_low) begin
            next_st.reload[7:0] = wbyte;
            next_st.pending = 1'b1;
        end
        if (wr_psc) begin
            next_st.prescale = wbyte;
        end

        // Counter
        // Retrigger outranks end of count, so one cycle never reloads twice
        if (start_edge && st.pending) begin
            // Constant rewritten while stopped replaces held value
            next_st.count = next_st.reload;
            next_st.pending = wr_high || wr_low;
        end else if (retrig) begin
            next_st.count = st.reload;
        end else if (eoc) begin
            next_st.count = next_st.reload;
            next_st.pending = wr_high || wr_low;
        end else if (psc_tick) begin
            next_st.count = st.count - 16'h0001;
        end

        // Control register; software set of run wins over hardware clear
        if (eoc && st.ctrl.single) begin
            next_st.ctrl.run_bit = 1'b0;
        end
        if (wr_ctrl) begin
            next_st.ctrl = ctrl_of_byte(wbyte);
        end

        // Trigger mode waits for an edge after the run bit is set
        if (!next_st.ctrl.run_bit) begin
            next_st.armed = 1'b0;
        end else if (running && pin_fall) begin
            next_st.armed = 1'b1;
        end

        // Output pin
        next_st.out_pin = out_next(st.ctrl, st.out_pin, eoc);

        // Interrupt channel carries either the timer or the external pin
        if (st.ctrl.irq_source_select) begin
            next_st.irq = ext_irq_pin;
        end else begin
            next_st.irq = eoc;
        end

        // Bus answer: one wait cycle, then waitrequest low for one cycle
        if (bus_req && st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.rdata = 32'h0000_0000;
            if (avs_read) begin
                next_st.rdata = {24'h00_0000, read_byte(avs_address, st)};
            end
        end
        if (bus_commit) begin
            next_st.waitreq = 1'b1;
        end
    end

    // Synchronous reset; every field takes a constant
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st.ctrl <= sdt_ctrl_t'(`SDT_RST_CONTROL);
            st.count <= {`SDT_RST_RELOAD_HIGH, `SDT_RST_RELOAD_LOW};
            st.reload <= {`SDT_RST_RELOAD_HIGH, `SDT_RST_RELOAD_LOW};
            st.prescale <= `SDT_RST_PRESCALE;
            st.pending <= 1'b0;
            st.armed <= 1'b0;
            st.sync_first <= 1'b1;
            st.sync_second <= 1'b1;
            st.pin_prev <= 1'b1;
            st.div_cnt <= 2'b00;
            st.out_pin <= 1'b1;
            st.irq <= 1'b0;
            st.waitreq <= 1'b1;
            st.rdata <= 32'h0000_0000;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign timer_output_pin = st.out_pin;
    assign irq_channel = st.irq;

endmodule

// >>> verification/sdt_monitor.sv
// Port-level checks of the down timer, bound into its top module
`timescale 1ns/1ns

module sdt_monitor #(
    parameter int ADDR_W = 10
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic count_input_pin,
    input wire logic oscillator_derived_clock,
    input wire logic ext_irq_pin,
    input wire logic timer_output_pin,
    input wire logic irq_channel
);
    // Shadow control bits; age keeps checks off the four cycles after a write
    logic ctl_sel;
    logic [1:0] ctl_out;
    logic [2:0] ctl_age;
    logic ctl_wr;
    logic quiet;
    assign ctl_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == ADDR_W'(10'h3CC);
    assign quiet = ctl_age > 3'h3;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl_sel <= 1'b1;
            ctl_out <= 2'b00;
            ctl_age <= 3'h0;
        end else if (ctl_wr) begin
            ctl_sel <= avs_writedata[2];
            ctl_out <= avs_writedata[1:0];
            ctl_age <= 3'h0;
        end else if (ctl_age != 3'h7) begin
            ctl_age <= ctl_age + 3'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered");
    AST_IDLE: assert property (!avs_read && !avs_write |=> avs_waitrequest)
        else $error("answer without request");
    AST_UNMAPPED: assert property (avs_read && !avs_waitrequest
        && avs_address[ADDR_W-1:4] != 6'h3C |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_EXT_MIRROR: assert property (ctl_sel && quiet |=> irq_channel == $past(ext_irq_pin))
        else $error("external interrupt not passed");
    AST_OUT_OFF: assert property (quiet && ctl_out == 2'b00 |-> timer_output_pin)
        else $error("output pin not high");
    AST_IRQ_PULSE: assert property (quiet && !ctl_sel && irq_channel |=> !irq_channel)
        else $error("timer interrupt longer than one cycle");
    AST_SQUARE: assert property (quiet && !ctl_sel && ctl_out == 2'b01 && irq_channel
        |-> $changed(timer_output_pin))
        else $error("square wave did not toggle");
    AST_PWM: assert property (quiet && !ctl_sel && ctl_out[1] && irq_channel
        |-> timer_output_pin == ctl_out[0])
        else $error("pwm level not copied");
    COV_TIMER_IRQ: cover property (quiet && !ctl_sel && irq_channel);
    COV_EXT_IRQ: cover property (ctl_sel && ext_irq_pin);
    COV_READ: cover property (avs_read && !avs_waitrequest);
endmodule

bind sdt_top sdt_monitor #(.ADDR_W(ADDR_W)) i_sdt_monitor (.clk_sys, .srst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .count_input_pin, .oscillator_derived_clock, .ext_irq_pin, .timer_output_pin, .irq_channel);

// >>> verification/sdt_pin_source.sv
// Model of the external source on the count, gate or trigger pin
`timescale 1ns/1ns

module sdt_pin_source (
    input wire logic clk_sys,
    output logic count_input_pin
);
    initial count_input_pin = 1'b1;
    task automatic set_level(input logic v);
        @(posedge clk_sys);
        count_input_pin <= v;
    endtask
    // Falling edges come gap clocks apart; callers never pass below 8
    task automatic edges(input int n, input int gap);
        repeat (n) begin
            set_level(1'b0);
            repeat (gap / 2) @(posedge clk_sys);
            set_level(1'b1);
            repeat (gap - gap / 2 - 2) @(posedge clk_sys);
        end
    endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the down timer over its Avalon-MM port
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; \
    if ((s) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end

module tb;
    logic clk_sys, srst, avs_read, avs_write, avs_waitrequest;
    logic count_input_pin, ext_irq_pin, timer_output_pin, irq_channel, o0;
    logic [9:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] rv;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    int n_irq = 0;
    int t0, t1, per;
    localparam logic [9:0] A_HI = 10'h3C0;
    localparam logic [9:0] A_LO = 10'h3C4;
    localparam logic [9:0] A_PSC = 10'h3C8;
    localparam logic [9:0] A_CTL = 10'h3CC;

    sdt_top #(.ADDR_W(10), .HAS_COUNT_PIN(1'b1)) i_sdt_top (.clk_sys, .srst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .count_input_pin, .oscillator_derived_clock(1'b0), .ext_irq_pin,
        .timer_output_pin, .irq_channel);
    sdt_pin_source i_sdt_pin_source (.clk_sys, .count_input_pin);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (irq_channel === 1'b1) n_irq <= n_irq + 1;
    end

    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic access(input logic [9:0] a, input logic wr_en, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr_en;
        avs_write <= wr_en;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        access(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        access(a, 1'b0, 8'h00);
        `CHK($sformatf("register %h", a), e, rv)
    endtask
    task automatic start(input logic [7:0] h, l, p, c);
        wr(A_CTL, 8'h00);
        wr(A_HI, h);
        wr(A_LO, l);
        wr(A_PSC, p);
        wr(A_CTL, c);
    endtask
    task automatic wait_irq(output int t);
        int k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (irq_channel !== 1'b1 && k < 600);
        `CHK("interrupt", 1'b1, irq_channel)
        t = cyc;
    endtask
    task automatic period(output int p);
        wait_irq(t0);
        wait_irq(t1);
        p = t1 - t0;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        conclude();
    end

    initial begin
        srst = 1'b1;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h1;
        ext_irq_pin = 1'b0;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        rdc(A_HI, 8'hFF);
        rdc(A_LO, 8'hFF);
        rdc(A_PSC, 8'hFF);
        rdc(A_CTL, 8'h14);
        rdc(10'h3D0, 8'h00);
        `CHK("output idle", 1'b1, timer_output_pin)
        ext_irq_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        `CHK("external irq", 1'b1, irq_channel)
        ext_irq_pin <= 1'b0;
        wr(A_PSC, 8'h5A);
        avs_byteenable <= 4'h0;
        wr(A_PSC, 8'h33);
        avs_byteenable <= 4'h1;
        rdc(A_PSC, 8'h5A);
        wr(A_HI, 8'h12);
        rdc(A_HI, 8'hFF);
        start(8'h00, 8'h03, 8'h00, 8'h81);
        period(per);
        `CHK("period", 16, per)
        o0 = timer_output_pin;
        wait_irq(t0);
        `CHK("square wave", ~o0, timer_output_pin)
        wr(A_PSC, 8'h01);
        period(per);
        `CHK("prescaled period", 32, per)
        wr(A_LO, 8'h07);
        wait_irq(t0);
        period(per);
        `CHK("new constant period", 64, per)
        wr(A_CTL, 8'h01);
        access(A_LO, 1'b0, 8'h00);
        repeat (30) @(posedge clk_sys);
        rdc(A_LO, rv);
        start(8'h00, 8'h02, 8'h00, 8'hC1);
        wait_irq(t0);
        rdc(A_CTL, 8'h41);
        rdc(A_LO, 8'h02);
        // Mode bits set but input section off: core clock still counts
        start(8'h00, 8'h02, 8'h00, 8'hA1);
        wait_irq(t0);
        start(8'h00, 8'h02, 8'h00, 8'h82);
        wait_irq(t0);
        wait_irq(t0);
        `CHK("pwm low", 1'b0, timer_output_pin)
        wr(A_CTL, 8'h83);
        wait_irq(t0);
        wait_irq(t0);
        `CHK("pwm high", 1'b1, timer_output_pin)
        wr(A_CTL, 8'h82);
        wait_irq(t0);
        wr(A_CTL, 8'h80);
        repeat (3) @(posedge clk_sys);
        `CHK("output off", 1'b1, timer_output_pin)
        start(8'h00, 8'h02, 8'h00, 8'h88);
        t1 = n_irq;
        i_sdt_pin_source.edges(2, 20);
        repeat (8) @(posedge clk_sys);
        `CHK("events before end", t1, n_irq)
        i_sdt_pin_source.edges(1, 8);
        repeat (8) @(posedge clk_sys);
        `CHK("events at end", t1 + 1, n_irq)
        start(8'h00, 8'h02, 8'h00, 8'hA8);
        repeat (40) @(posedge clk_sys);
        rdc(A_LO, 8'h02);
        i_sdt_pin_source.edges(1, 8);
        wait_irq(t0);
        start(8'h01, 8'h40, 8'h00, 8'hB8);
        repeat (60) @(posedge clk_sys);
        i_sdt_pin_source.edges(1, 8);
        access(A_LO, 1'b0, 8'h00);
        `CHK("retrigger reload", 1'b1, rv > 8'h38)
        i_sdt_pin_source.set_level(1'b0);
        start(8'h01, 8'h00, 8'h00, 8'h98);
        repeat (20) @(posedge clk_sys);
        rdc(A_HI, 8'h01);
        rdc(A_LO, 8'h00);
        i_sdt_pin_source.set_level(1'b1);
        repeat (40) @(posedge clk_sys);
        rdc(A_HI, 8'h00);
        conclude();
    end
endmodule
